// >>> src/sfpfe_front.sv
// pin front end of a serial flash: framing, lanes, guard, pause
`timescale 1ns/1ps
`default_nettype none
module sfpfe_front #(
    parameter logic [7:0]  MFR_ID = 8'h5a,   // arbitrary value
    parameter logic [7:0]  DEV_ID = 8'ha5,   // arbitrary value
    parameter logic [63:0] UID    = 64'h0123456789abcdef // arbitrary
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire sfpfe_pkg::sfpfe_req_t req,
    output logic [7:0]                rdata,
    input  wire logic                 cs_n_pin,
    input  wire logic                 sclk_pin,
    input  wire sfpfe_pkg::sfpfe_lane_t lane_in,
    output sfpfe_pkg::sfpfe_lane_t    lane_out,
    output sfpfe_pkg::sfpfe_lane_t    lane_oe,
    input  wire logic                 internal_busy,
    output logic                      power_active,
    output logic                      power_standby,
    output logic                      array_guard,
    output logic [4:0]                guard_zone
);
    // synchronised pins
    logic [5:0]  pin_s;         // {sclk, cs_n, lanes}
    logic [3:0]  lanes_s;       // lane levels
    logic        cs_s;          // select, high = deselected
    logic        sclk_s;        // serial clock level
    logic        sclk_d_q;      // clock level one cycle back
    logic        rise;          // clock rising edge seen
    logic        fall;          // clock falling edge seen

    // software visible state
    logic [7:0]  sr1_q;         // status_reg_one image
    logic [7:0]  sr2_q;         // status_reg_two image
    logic [7:0]  mode_q;        // width, command mode, direction
    logic [7:0]  tx_q;          // next byte to send
    logic [7:0]  rx_q;          // last data byte taken
    logic [7:0]  instr_q;       // last instruction byte
    logic [7:0]  cnt_q;         // bytes moved in this frame
    logic [7:0]  rdata_q;       // read answer
    logic [2:0]  uid_sel_q;     // serial number byte index
    logic [9:0]  sec_adr_q;     // security area pointer
    logic [7:0]  sec_mem [sfpfe_pkg::SEC_TOTAL];
    logic        refused_q;     // status write refused, sticky
    logic        rxnew_q;       // data byte arrived, sticky
    logic        pinrst_q;      // lane three reset seen, sticky

    // frame state
    logic        armed_q;       // select seen high since reset
    logic        paused_q;      // serial traffic suspended
    logic        guard_q;       // array guard level
    sfpfe_pkg::sfpfe_phase_t phase_q;
    logic [2:0]  bit_q;         // bit position within byte
    logic [7:0]  rx_sh_q;       // receive shifter
    logic [7:0]  tx_sh_q;       // send shifter
    logic [3:0]  out_q;         // driven lane levels

    // decoded controls
    logic        qe;            // quad_enable_bit
    logic        hold_fn;       // lane three is the pause pin
    logic        pinrst;        // lane three reset active
    logic        hold_low;      // pause pin asserted
    logic        locked;        // guard pin locks status regs
    logic        four_lane_command_mode;           // four_lane_command_mode usable
    logic [1:0]  dw;            // data phase width
    logic [1:0]  w;             // width of current phase
    logic [3:0]  step;          // bits per edge
    logic [3:0]  bit_sum;       // position plus step
    logic        sel;           // selected and accepted
    logic        dir_out;       // data phase drives lanes
    logic        step_rx;       // take bits this cycle
    logic        step_tx;       // send bits this cycle
    logic [7:0]  rx_nx;         // shifter after intake
    logic [7:0]  tx_src;        // byte being sent
    logic [3:0]  tx_bits;       // lanes for next send
    logic [7:0]  rd_mux;        // read selection
    logic        wr_sr;         // status register write

    sfpfe_sync #(
        .W (6)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({sclk_pin, cs_n_pin, lane_in}),
        .q    (pin_s)
    );

    assign lanes_s = pin_s[3:0];
    assign cs_s    = pin_s[4];
    assign sclk_s  = pin_s[5];

    // clock edge finder, works for idle low or high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_d_q; // R19
    assign fall = ~sclk_s & sclk_d_q;

    // lane three role and guard decode
    assign qe       = sr2_q[sfpfe_pkg::SR2_QE];
    assign hold_fn  = ~qe & ~sr2_q[sfpfe_pkg::SR2_RSTFN]; // R14
    assign pinrst   = ~qe & sr2_q[sfpfe_pkg::SR2_RSTFN] & ~lanes_s[3]; // R14
    assign hold_low = hold_fn & ~lanes_s[3];
    assign locked   = ~qe & ~sr2_q[sfpfe_pkg::SR2_UPPER]
                    & sr1_q[sfpfe_pkg::SR1_LOWER] & ~lanes_s[2]; // R07 R09
    assign four_lane_command_mode      = mode_q[sfpfe_pkg::MODE_QPI] & qe; // R18

    // quad data width only with quad enable
    always_comb begin
        dw = mode_q[1:0];
        if (dw == sfpfe_pkg::W_FOUR && !qe) begin
            dw = sfpfe_pkg::W_ONE; // R18
        end else if (dw == 2'h3) begin
            dw = sfpfe_pkg::W_ONE;
        end
    end

    assign sel     = armed_q & ~cs_s & ~pinrst; // R01 R03
    assign w       = (phase_q == sfpfe_pkg::PH_INSTR)
                   ? (four_lane_command_mode ? sfpfe_pkg::W_FOUR : sfpfe_pkg::W_ONE) // R15
                   : dw;
    assign step    = sfpfe_pkg::lane_step(w);
    assign bit_sum = {1'b0, bit_q} + step;
    assign dir_out = (phase_q == sfpfe_pkg::PH_DATA)
                   & mode_q[sfpfe_pkg::MODE_DRV];
    assign step_rx = sel & ~paused_q & rise & ~dir_out; // R04 R20
    assign step_tx = sel & ~paused_q & fall & dir_out; // R05 R20

    // intake shifter, lane one is the higher bit of a pair
    always_comb begin
        case (w)
            sfpfe_pkg::W_FOUR: rx_nx = {rx_sh_q[3:0], lanes_s}; // R10
            sfpfe_pkg::W_TWO:  rx_nx = {rx_sh_q[5:0], lanes_s[1:0]}; // R06
            default:           rx_nx = {rx_sh_q[6:0], lanes_s[0]};
        endcase
    end

    // send bits, single width leaves on lane one
    assign tx_src = (bit_q == 3'h0) ? tx_q : tx_sh_q;
    always_comb begin
        case (w)
            sfpfe_pkg::W_FOUR: tx_bits = tx_src[7:4]; // R10
            sfpfe_pkg::W_TWO:  tx_bits = {2'b00, tx_src[7:6]}; // R06
            default:           tx_bits = {2'b00, tx_src[7], 1'b0};
        endcase
    end

    // accept frames only after select seen high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else if (cs_s) begin
            armed_q <= 1'b1; // R03
        end
    end

    // pause state, set or released by the pause pin only while the clock is low; deselect clears it at any level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            paused_q <= 1'b0;
        end else if (!sel || !hold_fn) begin
            paused_q <= 1'b0; // R12
        end else if (!sclk_s) begin
            paused_q <= hold_low; // R12 R13
        end
    end

    // frame shifting; pause freezes position
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= sfpfe_pkg::PH_INSTR;
            bit_q   <= 3'h0;
            cnt_q   <= 8'h00;
            rx_sh_q <= 8'h00;
            tx_sh_q <= 8'h00;
            out_q   <= 4'h0;
            instr_q <= 8'h00;
            rx_q    <= 8'h00;
        end else if (!sel) begin
            // continuous read starts with the address
            phase_q <= mode_q[sfpfe_pkg::MODE_CONT]
                     ? sfpfe_pkg::PH_DATA : sfpfe_pkg::PH_INSTR; // R16
            bit_q   <= 3'h0;
            cnt_q   <= 8'h00;
            out_q   <= 4'h0;
        end else if (step_rx) begin
            rx_sh_q <= rx_nx; // R04
            bit_q   <= bit_sum[2:0];
            if (bit_sum[3]) begin
                cnt_q <= cnt_q + 8'h01;
                case (phase_q)
                    sfpfe_pkg::PH_INSTR: begin
                        instr_q <= rx_nx; // R15
                        phase_q <= sfpfe_pkg::PH_DATA;
                    end
                    default: begin
                        rx_q <= rx_nx;
                    end
                endcase
            end
        end else if (step_tx) begin
            out_q   <= tx_bits; // R05 R06
            tx_sh_q <= tx_src << step;
            bit_q   <= bit_sum[2:0];
            if (bit_sum[3]) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // register writes; guard lock refuses status writes
    assign wr_sr = req.wr
                 && (req.addr == sfpfe_pkg::A_SR1
                 || req.addr == sfpfe_pkg::A_SR2);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr1_q     <= sfpfe_pkg::SR1_RST;
            sr2_q     <= sfpfe_pkg::SR2_RST;
            mode_q    <= sfpfe_pkg::MODE_RST;
            tx_q      <= 8'h00;
            uid_sel_q <= 3'h0;
        end else if (req.wr) begin
            if (req.addr == sfpfe_pkg::A_SR1 && !locked) begin
                sr1_q <= req.wdata; // R07
            end else if (req.addr == sfpfe_pkg::A_SR2 && !locked) begin
                sr2_q <= req.wdata; // R07
            end else if (req.addr == sfpfe_pkg::A_MODE) begin
                mode_q <= req.wdata;
            end else if (req.addr == sfpfe_pkg::A_TX) begin
                tx_q <= req.wdata;
            end else if (req.addr == sfpfe_pkg::A_UIDSEL) begin
                uid_sel_q <= req.wdata[2:0];
            end
        end
    end

    // sticky flags, a new event beats a clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refused_q <= 1'b0;
            rxnew_q   <= 1'b0;
            pinrst_q  <= 1'b0;
        end else begin
            if (wr_sr && locked) begin
                refused_q <= 1'b1; // R07
            end else if (req.wr && req.addr == sfpfe_pkg::A_STAT
                         && req.wdata[3]) begin
                refused_q <= 1'b0;
            end
            if (step_rx && bit_sum[3] && phase_q == sfpfe_pkg::PH_DATA) begin
                rxnew_q <= 1'b1;
            end else if (req.wr && req.addr == sfpfe_pkg::A_STAT
                         && req.wdata[5]) begin
                rxnew_q <= 1'b0;
            end
            if (pinrst) begin
                pinrst_q <= 1'b1; // R14
            end else if (req.wr && req.addr == sfpfe_pkg::A_STAT
                         && req.wdata[6]) begin
                pinrst_q <= 1'b0;
            end
        end
    end

    // array guard follows the lock one cycle later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            guard_q <= 1'b0;
        end else begin
            guard_q <= locked; // R08 R09
        end
    end

    // security area pointer, steps on each data access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sec_adr_q <= 10'h000;
        end else if (req.wr && req.addr == sfpfe_pkg::A_SECLO) begin
            sec_adr_q <= {sec_adr_q[9:8], req.wdata};
        end else if (req.wr && req.addr == sfpfe_pkg::A_SECHI) begin
            sec_adr_q <= {req.wdata[1:0], sec_adr_q[7:0]};
        end else if ((req.wr || req.rd)
                     && req.addr == sfpfe_pkg::A_SECDAT) begin
            sec_adr_q <= (sec_adr_q >= 10'(sfpfe_pkg::SEC_TOTAL - 1))
                       ? 10'h000 : sec_adr_q + 10'h001; // R17
        end
    end

    // security area storage, no reset
    always_ff @(posedge clk) begin
        if (req.wr && req.addr == sfpfe_pkg::A_SECDAT
            && sec_adr_q < 10'(sfpfe_pkg::SEC_TOTAL)) begin
            sec_mem[sec_adr_q] <= req.wdata; // R17
        end
    end

    // read selection, unmapped reads zero
    always_comb begin
        if (req.addr == sfpfe_pkg::A_SR1) begin
            rd_mux = sr1_q;
        end else if (req.addr == sfpfe_pkg::A_SR2) begin
            rd_mux = sr2_q;
        end else if (req.addr == sfpfe_pkg::A_MODE) begin
            rd_mux = mode_q;
        end else if (req.addr == sfpfe_pkg::A_TX) begin
            rd_mux = tx_q;
        end else if (req.addr == sfpfe_pkg::A_RX) begin
            rd_mux = rx_q;
        end else if (req.addr == sfpfe_pkg::A_INSTR) begin
            rd_mux = instr_q;
        end else if (req.addr == sfpfe_pkg::A_STAT) begin
            rd_mux = {1'b0, pinrst_q, rxnew_q, guard_q,
                      refused_q, paused_q, armed_q, sel};
        end else if (req.addr == sfpfe_pkg::A_CNT) begin
            rd_mux = cnt_q;
        end else if (req.addr == sfpfe_pkg::A_MFR) begin
            rd_mux = MFR_ID; // R17
        end else if (req.addr == sfpfe_pkg::A_DEV) begin
            rd_mux = DEV_ID; // R17
        end else if (req.addr == sfpfe_pkg::A_UIDSEL) begin
            rd_mux = {5'h00, uid_sel_q};
        end else if (req.addr == sfpfe_pkg::A_UID) begin
            rd_mux = UID[{uid_sel_q, 3'h0} +: 8]; // R17
        end else if (req.addr == sfpfe_pkg::A_SECDAT
                     && sec_adr_q < 10'(sfpfe_pkg::SEC_TOTAL)) begin
            rd_mux = sec_mem[sec_adr_q];
        end else begin
            rd_mux = 8'h00;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= req.rd ? rd_mux : 8'h00;
        end
    end

    // outputs; lanes released unless sending
    assign rdata         = rdata_q;
    assign lane_out      = out_q;
    assign lane_oe       = (sel && !paused_q && dir_out)
                         ? sfpfe_pkg::lane_mask(dw) : 4'h0; // R01 R20
    assign power_active  = armed_q & ~cs_s; // R02
    assign power_standby = cs_s & ~internal_busy; // R02 R11
    assign array_guard   = guard_q; // R08
    assign guard_zone    = sr1_q[6:2];

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_desel_hiz;
        cs_s |-> lane_oe == 4'h0;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) // R01
        else $error("lanes driven while deselected");

    property p_standby;
        cs_s && !internal_busy |-> power_standby && !power_active;
    endproperty
    a_standby: assert property (p_standby) // R02
        else $error("standby not shown while idle");

    property p_armed;
        !armed_q |-> !sel && cnt_q == 8'h00;
    endproperty
    a_armed: assert property (p_armed) // R03
        else $error("frame accepted before select went high");

    property p_rx_edge;
        sel && $past(sel) && $changed(rx_sh_q) |-> $past(rise);
    endproperty
    a_rx_edge: assert property (p_rx_edge) // R04
        else $error("intake moved without rising clock");

    property p_tx_edge;
        sel && $past(sel) && $changed(out_q) |-> $past(fall);
    endproperty
    a_tx_edge: assert property (p_tx_edge) // R05
        else $error("output changed without falling clock");

    property p_sr_refuse;
        wr_sr && locked
            |=> $stable(sr1_q) && $stable(sr2_q) && refused_q;
    endproperty
    a_sr_refuse: assert property (p_sr_refuse) // R07
        else $error("status write taken while locked");

    property p_guard;
        locked |=> array_guard;
    endproperty
    a_guard: assert property (p_guard) // R08
        else $error("array guard missing while locked");

    property p_qe_noguard;
        qe && $past(qe) |-> !array_guard;
    endproperty
    a_qe_noguard: assert property (p_qe_noguard) // R09
        else $error("guard active with quad enable set");

    property p_pause_in;
        $rose(paused_q) |-> $past(!sclk_s && hold_low);
    endproperty
    a_pause_in: assert property (p_pause_in) // R12
        else $error("pause entered with clock high");

    property p_pause_out;
        $fell(paused_q) && $past(sel) && sel |-> $past(!sclk_s);
    endproperty
    a_pause_out: assert property (p_pause_out) // R13
        else $error("pause left with clock high");

    property p_pause_hold;
        paused_q |-> lane_oe == 4'h0 ##1 (!paused_q || $stable(bit_q));
    endproperty
    a_pause_hold: assert property (p_pause_hold) // R20
        else $error("paused but lanes driven or position moved");

    c_instr: cover property (sel && step_rx && bit_sum[3]
                             && phase_q == sfpfe_pkg::PH_INSTR);
    c_quad_out: cover property (step_tx && w == sfpfe_pkg::W_FOUR);
    c_pause: cover property ($rose(paused_q) ##[1:40] $fell(paused_q));
    c_refuse: cover property ($rose(refused_q));
endmodule
`default_nettype wire

// >>> pkg/sfpfe_pkg.sv
// constants, carriers and helpers for the serial flash pin front end
//
// Notes on behaviour
// R01: select high: deselected, inputs ignored, outputs released
// R02: deselected and idle internally means standby power
// R03: no instruction before select seen high, then low
// R04: instruction, address, write data taken on rising clock
// R05: output data changes only after falling clock
// R06: dual/quad: lanes zero, one bidirectional, same edges
// R07: guard pin low and locked: status writes refused
// R08: locked and guard low: protected array regions blocked
// R09: quad enable set disables the guard pin function
// R10: quad: lane two carries data on same edges
// R11: pause stops serial traffic, not internal operations
// R12: pause needs select low; enters when clock low
// R13: pause ends on pause pin high, clock low
// R14: lane three pause or reset only without quad enable
// R15: four-lane command mode: instruction in two clocks
// R16: continuous read skips instruction byte, address first
// R17: identity, 64-bit serial, three 256-byte security areas
// R18: quad transfers need quad enable bit set
// R19: clock polarity and phase modes 0 and 3 work
// R20: paused: ignore lanes, release outputs, keep bit position
package sfpfe_pkg;

    // register addresses
    localparam logic [3:0] A_SR1    = 4'h0;
    localparam logic [3:0] A_SR2    = 4'h1;
    localparam logic [3:0] A_MODE   = 4'h2;
    localparam logic [3:0] A_TX     = 4'h3;
    localparam logic [3:0] A_RX     = 4'h4;
    localparam logic [3:0] A_INSTR  = 4'h5;
    localparam logic [3:0] A_STAT   = 4'h6;
    localparam logic [3:0] A_CNT    = 4'h7;
    localparam logic [3:0] A_MFR    = 4'h8;
    localparam logic [3:0] A_DEV    = 4'h9;
    localparam logic [3:0] A_UIDSEL = 4'ha;
    localparam logic [3:0] A_UID    = 4'hb;
    localparam logic [3:0] A_SECLO  = 4'hc;
    localparam logic [3:0] A_SECHI  = 4'hd;
    localparam logic [3:0] A_SECDAT = 4'he;

    // field positions
    localparam int SR1_LOWER = 7;   // lock_bit_lower
    localparam int SR2_UPPER = 0;   // lock_bit_upper
    localparam int SR2_QE    = 1;   // quad_enable_bit
    localparam int SR2_RSTFN = 2;   // lane three acts as reset pin
    localparam int MODE_QPI  = 2;   // four_lane_command_mode
    localparam int MODE_CONT = 3;   // continuous read
    localparam int MODE_DRV  = 4;   // data phase drives lanes

    // reset values
    localparam logic [7:0] SR1_RST  = 8'h00;
    localparam logic [7:0] SR2_RST  = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;

    // lane width codes
    localparam logic [1:0] W_ONE  = 2'h0;
    localparam logic [1:0] W_TWO  = 2'h1;
    localparam logic [1:0] W_FOUR = 2'h2;

    // security area size
    localparam int SEC_TOTAL = 768;

    // frame phases
    typedef enum logic [0:0] {PH_INSTR, PH_DATA} sfpfe_phase_t;

    // the four data lanes, bit 0 is lane_zero
    typedef struct packed {
        logic lane_three;
        logic lane_two;
        logic lane_one;
        logic lane_zero;
    } sfpfe_lane_t;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } sfpfe_req_t;

    // bits moved per clock edge
    function automatic logic [3:0] lane_step(input logic [1:0] w);
        if (w == W_FOUR) begin
            return 4'h4;
        end else if (w == W_TWO) begin
            return 4'h2;
        end
        return 4'h1;
    endfunction

    // lanes driven while sending
    function automatic logic [3:0] lane_mask(input logic [1:0] w);
        if (w == W_FOUR) begin
            return 4'hf;
        end else if (w == W_TWO) begin
            return 4'h3;
        end
        return 4'h2;
    endfunction

endpackage

// >>> src/sfpfe_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfpfe_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;   // first stage, read only by q

    // two stages, no logic between
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> verification/sfpfe_host.sv
// host controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module sfpfe_host (
    output var logic                    cs_n,
    output var logic                    sclk,
    output var sfpfe_pkg::sfpfe_lane_t  drv,
    output var sfpfe_pkg::sfpfe_lane_t  oe,
    input  wire sfpfe_pkg::sfpfe_lane_t lvl
);
    logic wp_n;   // guard pin level
    logic hold_n; // pause pin level
    logic bit_q;  // bit on lane zero
    // select left low: first frame skips the high
    initial begin
        cs_n  = 1'b0;
        sclk  = 1'b0;
        wp_n  = 1'b1;
        hold_n = 1'b1;
        bit_q = 1'b0;
    end
    // lane zero only while selected, guard and pause always
    always_comb begin
        drv = '{hold_n, wp_n, 1'b0, bit_q};
        oe  = '{1'b1, 1'b1, 1'b0, ~cs_n};
    end
    // move select off the clock grid, let it settle
    task automatic sel(input logic v);
        #7 cs_n = v;
        #400;
    endtask
    // one byte, msb first, clock idles low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_q = tx[i];
            #100 sclk = 1'b1;
            rx[i] = lvl.lane_one;
            #200 sclk = 1'b0;
            #100;
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/sfpfe_front_tb_top.sv
// self-checking bench for the flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpfe_front_tb_top;
    logic                   clk;        // system clock
    logic                   rstn;       // async reset
    logic                   busy;       // internal operation running
    logic                   tog;        // undriven lane pattern
    logic                   rd_p;       // read taken last cycle
    logic                   cs_n;       // select pin
    logic                   sclk;       // serial clock pin
    logic                   act;        // active power
    logic                   stby;       // standby power
    logic                   grd;        // array guard
    logic [4:0]             zone;       // guard zone
    logic [7:0]             rdata;      // register data
    logic [7:0]             rx;         // byte seen by host
    logic [7:0]             tx;         // random byte
    logic [31:0]            seed;       // xorshift state
    int                     n_mismatch; // failures
    int                     tests_run;  // checks
    int                     cyc;        // hang guard
    logic [7:0]             q[$];       // expected reads
    sfpfe_pkg::sfpfe_req_t  req;        // register request
    sfpfe_pkg::sfpfe_lane_t d_out, d_oe, h_drv, h_oe, lvl;
    // wire level from both drivers, toggling when released
    assign lvl = (d_oe & d_out) | (~d_oe & h_oe & h_drv)
               | (~d_oe & ~h_oe & {4{tog}});
    sfpfe_front i_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
        .cs_n_pin(cs_n), .sclk_pin(sclk), .lane_in(lvl), .lane_out(d_out),
        .lane_oe(d_oe), .internal_busy(busy), .power_active(act),
        .power_standby(stby), .array_guard(grd), .guard_zone(zone));
    sfpfe_host i_host (.cs_n(cs_n), .sclk(sclk), .drv(h_drv), .oe(h_oe),
        .lvl(lvl));
    // system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one bus cycle; reads note d as expected data
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{w, ~w, a, d};
        if (!w) begin
            q.push_back(d);
        end
        @(posedge clk);
        req <= '0;
    endtask
    // read monitor, release pattern and hang guard
    always @(posedge clk) begin
        tog <= ~tog;
        cyc <= cyc + 1;
        rd_p <= req.rd;
        if (rd_p) begin
            chk(rdata, q.pop_front());
        end
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        busy = 1'b0;
        req = '0;
        tog = 1'b0;
        rd_p = 1'b0;
        cyc = 0;
        n_mismatch = 0;
        tests_run = 0;
        seed = 32'h37577950;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, sfpfe_pkg::A_SR1, sfpfe_pkg::SR1_RST);
        bus(1'b0, sfpfe_pkg::A_SR2, sfpfe_pkg::SR2_RST);
        bus(1'b0, 4'hf, 8'h00);
        i_host.xfer(8'ha5, rx);
        bus(1'b0, sfpfe_pkg::A_CNT, 8'h00);
        i_host.sel(1'b1);
        @(negedge clk);
        chk({7'h0, stby}, 8'h01);
        @(posedge clk);
        busy <= 1'b1;
        @(negedge clk);
        chk({7'h0, stby}, 8'h00);
        @(posedge clk);
        busy <= 1'b0;
        seed = xs(seed);
        tx = seed[7:0];
        bus(1'b1, sfpfe_pkg::A_TX, tx);
        bus(1'b1, sfpfe_pkg::A_MODE, 8'h10);
        i_host.sel(1'b0);
        @(negedge clk);
        chk({7'h0, act}, 8'h01);
        i_host.xfer(8'h3c, rx);
        // pause mid frame with clock low, select held low
        i_host.hold_n = 1'b0;
        repeat (4) @(negedge clk);
        chk({4'h0, d_oe}, 8'h00);
        i_host.hold_n = 1'b1;
        repeat (4) @(negedge clk);
        i_host.xfer(8'h00, rx);
        chk(rx, tx);
        i_host.sel(1'b1);
        @(negedge clk);
        chk({4'h0, d_oe}, 8'h00);
        bus(1'b0, sfpfe_pkg::A_INSTR, 8'h3c);
        i_host.wp_n = 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b1, sfpfe_pkg::A_SR1, 8'h9c);
        bus(1'b1, sfpfe_pkg::A_SR2, 8'h02);
        bus(1'b0, sfpfe_pkg::A_SR2, 8'h00);
        @(negedge clk);
        chk({2'h0, grd, zone}, 8'h27);
        i_host.wp_n = 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b1, sfpfe_pkg::A_SR2, 8'h02);
        i_host.wp_n = 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b1, sfpfe_pkg::A_SR2, 8'h03);
        bus(1'b0, sfpfe_pkg::A_SR2, 8'h03);
        @(negedge clk);
        chk({7'h0, grd}, 8'h00);
        // let the monitor compare the last read
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
